// [rtl/kwd_watchdog.sv]
// module: keyed watchdog timer with axi4-lite register slave
//
// Behaviour
// - time-out requests system reset unless disabled
// - stall while debug halted and pause set
// - debug mode overflow irq only if enabled
// - clear-interrupt write clears pending overflow
// - key register reads fixed protection key
// - key write unlocks time-out register once
// - limit N gives reset after N+1 cycles
// - relock time-out register after one write
// - keyed debug write disables reset generation
// - keyed control write with run bit starts
// - key write restarts counter from zero
// - control write with wrong key ignored
// - counter stops when it matches limit
`timescale 1ns/1ps
module kwd_watchdog
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cpu_debug_halted,
   output logic             reset_request,
   output logic             overflow_irq
);

   // ------------------------------------------------------------
   // write channel: take address and data in either order
   // ------------------------------------------------------------
   logic [11:0]       aw_addr;
   logic              aw_held;
   logic [31:0]       w_data;
   logic              w_held;
   logic              w_full;
   logic              aw_take;
   logic              w_take;
   logic              wr_fire;
   logic [11:0]       wr_addr_now;
   logic [31:0]       wr_data_now;
   logic              wr_map_hit;
   kwd_pkg::kwd_wr_t  wr;

   // partial byte writes are refused: keyed values must arrive whole
   assign aw_take     = s_axi_awvalid && s_axi_awready;
   assign w_take      = s_axi_wvalid && s_axi_wready;
   assign wr_addr_now = aw_held ? aw_addr : s_axi_awaddr;
   assign wr_data_now = w_held ? w_data : s_axi_wdata;
   assign wr_fire     = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
   assign w_full      = (s_axi_wstrb == 4'hF);
   assign wr          = {wr_fire, wr_addr_now, wr_data_now};

   // address holding
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
      end
      else if (wr_fire)
         aw_held <= 1'b0;
      else if (aw_take)
      begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
   end

   // data holding, strobe check folded into the error flag
   logic w_bad;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_bad  <= 1'b0;
      end
      else if (wr_fire)
         w_held <= 1'b0;
      else if (w_take)
      begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_bad  <= !w_full;
      end
   end

   logic wr_bad_now;
   assign wr_bad_now = w_held ? w_bad : !w_full;

   // ready and response flops
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= kwd_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid && !wr_fire;
         s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid && !wr_fire;
         if (wr_fire)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_bad_now || !wr_map_hit) ? kwd_pkg::RESP_SLVERR
                                                         : kwd_pkg::RESP_OKAY;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   logic wr_ok;
   logic wr_ctrl;
   logic wr_key;
   logic wr_limit;
   logic wr_debug;
   logic wr_clr_en;
   logic wr_set_en;
   logic wr_clr_stat;
   logic wr_set_stat;
   logic [31:0] ctrl_unkeyed;
   logic        ctrl_key_ok;
   logic        key_match;

   assign wr_ok        = wr.strobe && !wr_bad_now;
   assign wr_ctrl      = wr_ok && (wr.addr == kwd_pkg::OFS_TIMER_CONTROL);
   assign wr_key       = wr_ok && (wr.addr == kwd_pkg::OFS_SERVICE_KEY);
   assign wr_limit     = wr_ok && (wr.addr == kwd_pkg::OFS_EXPIRY_LIMIT);
   assign wr_debug     = wr_ok && (wr.addr == kwd_pkg::OFS_DEBUG_CONTROL);
   assign wr_clr_en    = wr_ok && (wr.addr == kwd_pkg::OFS_INT_CLR_EN);
   assign wr_set_en    = wr_ok && (wr.addr == kwd_pkg::OFS_INT_SET_EN);
   assign wr_clr_stat  = wr_ok && (wr.addr == kwd_pkg::OFS_INT_CLR_STAT);
   assign wr_set_stat  = wr_ok && (wr.addr == kwd_pkg::OFS_INT_SET_STAT);
   assign wr_map_hit   = (wr.addr == kwd_pkg::OFS_TIMER_CONTROL) ||
                         (wr.addr == kwd_pkg::OFS_TICK_COUNT) ||
                         (wr.addr == kwd_pkg::OFS_SERVICE_KEY) ||
                         (wr.addr == kwd_pkg::OFS_EXPIRY_LIMIT) ||
                         (wr.addr == kwd_pkg::OFS_DEBUG_CONTROL) ||
                         (wr.addr == kwd_pkg::OFS_INT_CLR_EN) ||
                         (wr.addr == kwd_pkg::OFS_INT_SET_EN) ||
                         (wr.addr == kwd_pkg::OFS_INT_CLR_STAT) ||
                         (wr.addr == kwd_pkg::OFS_INT_SET_STAT);
   assign key_match    = (wr.data == kwd_pkg::PROTECT_KEY);
   // key field is bits 31..3 after xor with the three control bits
   // key check
   assign ctrl_unkeyed = wr.data ^ {29'h0, wr.data[2:0]};
   assign ctrl_key_ok  = (ctrl_unkeyed[31:3] == kwd_pkg::PROTECT_KEY[31:3]);

   // ------------------------------------------------------------
   // control, lock and debug state
   // ------------------------------------------------------------
   logic [2:0]  ctrl;
   logic [31:0] limit;
   logic        unlocked;
   logic        rst_disable;
   logic [31:0] debug_unkeyed;
   logic        debug_key_ok;

   assign debug_unkeyed = wr.data ^ {31'h0, wr.data[kwd_pkg::BIT_RST_DISABLE]};
   assign debug_key_ok  = (debug_unkeyed == kwd_pkg::PROTECT_KEY);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl <= kwd_pkg::RST_CONTROL;
      else if (wr_ctrl && ctrl_key_ok)
         ctrl <= wr.data[2:0] ^ kwd_pkg::PROTECT_KEY[2:0];
   end

   // limit N matches after N cycles; reset request follows one cycle later
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         unlocked <= 1'b0;
         limit    <= kwd_pkg::RST_EXPIRY_LIMIT;
      end
      else if (wr_limit)
      begin
         if (unlocked)
         begin
            limit    <= wr.data;
            unlocked <= 1'b0;
         end
         else if (key_match)
            unlocked <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rst_disable <= 1'b0;
      else if (wr_debug && debug_key_ok)
         rst_disable <= wr.data[kwd_pkg::BIT_RST_DISABLE];
   end

   // ------------------------------------------------------------
   // debug status pin: three-stage synchroniser
   // ------------------------------------------------------------
   logic [2:0] halt_sync;
   logic       halted;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         halt_sync <= 3'h0;
         halted    <= 1'b0;
      end
      else
      begin
         halt_sync <= {halt_sync[1:0], cpu_debug_halted};
         if (halt_sync[1] == halt_sync[2])
            halted <= halt_sync[2];
      end
   end

   // ------------------------------------------------------------
   // tick counter
   // ------------------------------------------------------------
   kwd_pkg::kwd_stat_t stat;
   logic               stall;
   logic               restart;

   assign stall   = halted && ctrl[kwd_pkg::BIT_PAUSE];
   assign restart = wr_key && key_match;

   kwd_tick_core u_core
   (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .run        (ctrl[kwd_pkg::BIT_RUN]),
      .hold_clear (ctrl[kwd_pkg::BIT_CLEAR]),
      .stall      (stall),
      .restart    (restart),
      .limit      (limit),
      .stat       (stat)
   );

   // ------------------------------------------------------------
   // overflow status, enable and outputs
   // ------------------------------------------------------------
   logic irq_status;
   logic irq_enable;
   logic expired_q;
   logic expire_evt;

   assign expire_evt = stat.expired && !expired_q;

   // set wins over a clear in the same cycle
   // clear on write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         expired_q  <= 1'b0;
         irq_status <= 1'b0;
         irq_enable <= 1'b0;
      end
      else
      begin
         expired_q <= stat.expired;
         if (expire_evt || (wr_set_stat && wr.data[kwd_pkg::BIT_OVERFLOW]))
            irq_status <= 1'b1;
         else if (wr_clr_stat && wr.data[kwd_pkg::BIT_OVERFLOW])
            irq_status <= 1'b0;
         if (wr_set_en && wr.data[kwd_pkg::BIT_OVERFLOW])
            irq_enable <= 1'b1;
         else if (wr_clr_en && wr.data[kwd_pkg::BIT_OVERFLOW])
            irq_enable <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reset_request <= 1'b0;
         overflow_irq  <= 1'b0;
      end
      else
      begin
         reset_request <= stat.expired && !rst_disable;
         overflow_irq  <= irq_status && irq_enable;
      end
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   logic [31:0] rd_value;
   logic        rd_hit;
   logic [11:0] ra;
   assign ra = s_axi_araddr;

   always_comb
   begin
      rd_hit   = 1'b1;
      rd_value = 32'h00000000;
      if (ra == kwd_pkg::OFS_TIMER_CONTROL)
         rd_value = {29'h0, ctrl};
      else if (ra == kwd_pkg::OFS_TICK_COUNT)
         rd_value = stat.count;
      else if (ra == kwd_pkg::OFS_SERVICE_KEY)
         rd_value = kwd_pkg::PROTECT_KEY;
      else if (ra == kwd_pkg::OFS_EXPIRY_LIMIT)
         rd_value = limit;
      else if (ra == kwd_pkg::OFS_DEBUG_CONTROL)
         rd_value = {31'h0, rst_disable};
      else if (ra == kwd_pkg::OFS_INT_STATUS)
         rd_value = {31'h0, irq_status};
      else if (ra == kwd_pkg::OFS_INT_ENABLE)
         rd_value = {31'h0, irq_enable};
      else
         rd_hit = 1'b0;
   end

   // one read at a time; answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= kwd_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_value;
         s_axi_rresp   <= rd_hit ? kwd_pkg::RESP_OKAY : kwd_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid)
      begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else
         s_axi_arready <= 1'b1;
   end

endmodule

// [rtl/kwd_pkg.sv]
// package: register map, keys, field layout and bus carriers for the keyed watchdog
package kwd_pkg;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_TIMER_CONTROL = 12'h000;
   localparam logic [11:0] OFS_TICK_COUNT    = 12'h004;
   localparam logic [11:0] OFS_SERVICE_KEY   = 12'h038;
   localparam logic [11:0] OFS_EXPIRY_LIMIT  = 12'h03C;
   localparam logic [11:0] OFS_DEBUG_CONTROL = 12'h040;
   localparam logic [11:0] OFS_INT_CLR_EN    = 12'hFD8;
   localparam logic [11:0] OFS_INT_SET_EN    = 12'hFDC;
   localparam logic [11:0] OFS_INT_STATUS    = 12'hFE0;
   localparam logic [11:0] OFS_INT_ENABLE    = 12'hFE4;
   localparam logic [11:0] OFS_INT_CLR_STAT  = 12'hFE8;
   localparam logic [11:0] OFS_INT_SET_STAT  = 12'hFEC;

   // ------------------------------------------------------------
   // key, reset values and field positions
   // ------------------------------------------------------------
   localparam logic [31:0] PROTECT_KEY       = 32'h251D8950;
   localparam logic [31:0] RST_EXPIRY_LIMIT  = 32'h00FFFFFF;
   localparam logic [31:0] RST_TICK_COUNT    = 32'h00000000;
   localparam logic [2:0]  RST_CONTROL       = 3'h0;
   localparam int          BIT_RUN           = 0;
   localparam int          BIT_CLEAR         = 1;
   localparam int          BIT_PAUSE         = 2;
   localparam int          BIT_RST_DISABLE   = 0;
   localparam int          BIT_OVERFLOW      = 0;

   // ------------------------------------------------------------
   // axi response codes
   // ------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   // one accepted register write
   typedef struct packed {
      logic        strobe;
      logic [11:0] addr;
      logic [31:0] data;
   } kwd_wr_t;

   // timer status as seen by software
   typedef struct packed {
      logic [31:0] count;
      logic        expired;
   } kwd_stat_t;

endpackage

// [rtl/kwd_tick_core.sv]
// module: tick counter with restart, stall, clear and time-out compare
`timescale 1ns/1ps
module kwd_tick_core
(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                run,
   input  wire logic                hold_clear,
   input  wire logic                stall,
   input  wire logic                restart,
   input  wire logic [31:0]         limit,
   output kwd_pkg::kwd_stat_t       stat
);

   logic [31:0] count;
   logic        at_limit;
   logic        advance;
   logic [31:0] next_count;

   // time-out seen in the cycle the count equals the limit
   // equality compare
   assign at_limit = (count == limit);
   assign advance  = run && !stall && !at_limit;
   assign stat     = {count, at_limit && run};

   // restart and clear take priority over counting
   // restart from zero
   assign next_count = (restart || hold_clear) ? kwd_pkg::RST_TICK_COUNT :
                       advance ? count + 32'h00000001 : count;

   // counter register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count <= kwd_pkg::RST_TICK_COUNT;
      else
         count <= next_count;
   end

endmodule

// [testbench/kwd_watchdog_assertions.sv]
// checker: bus handshake and watchdog output properties at the top ports
`timescale 1ns/1ps
module kwd_watchdog_assertions
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        reset_request,
   input wire logic        overflow_irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // full-word write with address and data taken on one edge
   wire logic w_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                       && s_axi_wstrb == 4'hF;
   wire logic r_take = s_axi_arvalid && s_axi_arready;
   a_read_answer: assert property (r_take |=> s_axi_rvalid)
      else $error("read answer missing");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_write_answer: assert property (w_take |=> s_axi_bvalid)
      else $error("write answer missing");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_key_read: assert property (
      r_take && s_axi_araddr == kwd_pkg::OFS_SERVICE_KEY |=> s_axi_rdata == kwd_pkg::PROTECT_KEY)
      else $error("key register read wrong");
   a_unmapped_error: assert property (r_take && s_axi_araddr == 12'h100 |=> s_axi_rresp == 2'h2)
      else $error("unmapped read not refused");
   a_key_restart: assert property (
      w_take && s_axi_awaddr == 12'h038 && s_axi_wdata == kwd_pkg::PROTECT_KEY
      |=> ##[0:3] !reset_request)
      else $error("key write did not restart");
   a_irq_clear: assert property (
      w_take && s_axi_awaddr == kwd_pkg::OFS_INT_CLR_STAT && s_axi_wdata[0] |=> ##[0:3] !overflow_irq)
      else $error("overflow request not cleared");
   a_expiry_holds: assert property (
      reset_request && !s_axi_wvalid && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2)
      |=> reset_request)
      else $error("reset request dropped without a write");
endmodule

bind kwd_watchdog kwd_watchdog_assertions u_chk
(
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .reset_request(reset_request), .overflow_irq(overflow_irq)
);

// [testbench/kwd_far_model.sv]
// far-side model: processor debug status and reset generation unit
`timescale 1ns/1ps
module kwd_far_model
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic halt_cmd,
   input  wire logic reset_request,
   output logic      cpu_debug_halted,
   output int        reset_count
);
   logic seen;
   always_ff @(posedge aclk)
      cpu_debug_halted <= halt_cmd;
   // reset requests counted
   // level request, so only rising ones count as new resets
   always_ff @(posedge aclk)
   begin
      seen <= aresetn && reset_request;
      if (!aresetn)
         reset_count <= 0;
      else if (reset_request && !seen)
         reset_count <= reset_count + 1;
   end
endmodule

// [testbench/keyed_watchdog_timer_tb_top.sv]
// testbench: register bus scenarios for the keyed watchdog
`timescale 1ns/1ps
module keyed_watchdog_timer_tb_top;
   localparam logic [31:0] KEY = kwd_pkg::PROTECT_KEY;
   logic aclk, aresetn, halt_cmd, cpu_debug_halted, reset_request, overflow_irq;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, bsp;
   int fail_count, num_checks, reset_count, c1, c2;

   kwd_watchdog u_dut
   (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .cpu_debug_halted(cpu_debug_halted), .reset_request(reset_request),
      .overflow_irq(overflow_irq)
   );
   kwd_far_model u_far
   (
      .aclk(aclk), .aresetn(aresetn), .halt_cmd(halt_cmd), .reset_request(reset_request),
      .cpu_debug_halted(cpu_debug_halted), .reset_count(reset_count)
   );

   // ------------------------------------------------------------
   // bus master and comparison helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // address and data offered together, each dropped once taken
   // no cycle limit here: a dead bus is caught by the watchdog process
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      bsp = s_axi_bresp;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk(e, rdv);
   endtask
   // cycles until the request is seen again, after any old one drops
   task automatic wait_rst(output int c);
      c = 0;
      while (reset_request === 1'b1 && c < 9) begin @(posedge aclk); c++; end
      while (reset_request !== 1'b1 && c < 3000) begin @(posedge aclk); c++; end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rdchk(12'h038, 32'h251D8950);
      rdchk(12'h03C, kwd_pkg::RST_EXPIRY_LIMIT);
      rdchk(12'h000, 32'h0);
      rd(12'h100);
      chk(32'h2, {30'h0, rsp});
      wr(12'h100, 32'h0);
      chk(32'h2, {30'h0, bsp});
      // partial strobes must be refused, so the limit stays locked
      s_axi_wstrb <= 4'h1;
      wr(12'h03C, KEY);
      s_axi_wstrb <= 4'hF;
      chk(32'h2, {30'h0, bsp});
   endtask
   task automatic t_lock;
      wr(12'h03C, 32'h14);
      rdchk(12'h03C, 32'h00FFFFFF);
      wr(12'h03C, KEY);
      chk(32'h0, {30'h0, bsp});
      wr(12'h03C, 32'h14);
      rdchk(12'h03C, 32'h14);
      wr(12'h03C, 32'h1E);
      rdchk(12'h03C, 32'h14);
   endtask
   task automatic t_ctrl;
      wr(12'h000, 32'h12345671);
      rdchk(12'h000, 32'h0);
      wr(12'h000, KEY ^ 32'h1);
      rdchk(12'h000, 32'h1);
   endtask
   task automatic t_expiry;
      wait_rst(c1);
      chk(32'h1, {31'h0, reset_request});
      // the far model counts on this same edge, so look one edge later
      @(posedge aclk);
      chk(32'h1, {31'h0, reset_count != 0});
      rdchk(12'h004, 32'h14);
      repeat (5) @(posedge aclk);
      rdchk(12'h004, 32'h14);
      wr(12'h038, KEY);
      wait_rst(c1);
      wr(12'h03C, KEY);
      wr(12'h03C, 32'h28);
      wr(12'h038, KEY);
      wait_rst(c2);
      chk(32'd21, c1);
      chk(32'd41, c2);
      chk(32'd20, c2 - c1);
   endtask
   // restarts every few cycles, well inside the 40-cycle limit
   task automatic t_service;
      repeat (8)
      begin
         wr(12'h038, KEY);
         // request drops one edge after the restart lands
         @(posedge aclk);
         chk(32'h0, {31'h0, reset_request});
      end
   endtask
   task automatic t_debug;
      wr(12'h040, KEY ^ 32'h1);
      rdchk(12'h040, 32'h1);
      wr(12'h038, KEY);
      repeat (60) @(posedge aclk);
      chk(32'h0, {31'h0, reset_request});
      chk(32'h0, {31'h0, overflow_irq});
      rdchk(12'hFE0, 32'h1);
      wr(12'hFDC, 32'h1);
      repeat (3) @(posedge aclk);
      chk(32'h1, {31'h0, overflow_irq});
      wr(12'hFE8, 32'h1);
      repeat (3) @(posedge aclk);
      chk(32'h0, {31'h0, overflow_irq});
      wr(12'hFD8, 32'h1);
      wr(12'h040, KEY);
      repeat (3) @(posedge aclk);
      chk(32'h1, {31'h0, reset_request});
   endtask
   // halt synchroniser needs a few cycles, so waits stay generous
   task automatic t_pause;
      wr(12'h000, KEY ^ 32'h5);
      halt_cmd <= 1'b1;
      repeat (8) @(posedge aclk);
      wr(12'h038, KEY);
      repeat (10) @(posedge aclk);
      rdchk(12'h004, 32'h0);
      halt_cmd <= 1'b0;
      repeat (10) @(posedge aclk);
      rd(12'h004);
      chk(32'h1, {31'h0, rdv != 32'h0});
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   initial
   begin
      #500000;
      fail_count++;
      close_out();
   end
   initial
   begin
      {aresetn, halt_cmd, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_lock();
      t_ctrl();
      t_expiry();
      t_service();
      t_debug();
      t_pause();
      close_out();
   end
endmodule
